// ---- rtl/ext_bus_cfg.svh ----
/*
  constants for the external bus block: register offsets, field positions,
  reset values, window limits and state timing.
  assumes a 25 MHz clock and a 32-bit classic wishbone register port.
*/
// What this block does
// - mode pins size the external window; 10 prohibited; ram at FF00H-FFFFH
// - full expansion: big-ram variant external to FBFFH, ram FC00H; other to FEFFH
// - low port carries muxed address/data, high port upper address, with strobes
// - high-port pins not needed as address stay general-purpose in 4K and 16K
// - bus-mode field in low three bits must be zero on romless variants
// - on-chip ram decoded only while ram enable is 1, else external in full expansion
// - ram enable survives ordinary reset; undefined after power-on
// - bus state advances once every three oscillator clocks
// - read and write cycles take three states; opcode fetch takes four
// - no wait states: every cycle runs its fixed length
// - fetch reads memory in states one to three, decodes in four
// - fetch holds upper address byte from start of state one to end of four
// - low address byte driven only in state one, then bus released
// - latch strobe pulses in state one of every machine cycle
// - fetch read strobe low from mid state one to start of state four
// - data read: read strobe low from mid state one to start of state three
// - write data driven states two and three; write strobe mid one to start three
// - internal cycles keep strobes high but emit latch strobe and address
// - port output in full expansion emits a write strobe pulse during the next core cycle, if written while idle
// - eprom range field limits eprom to 0FFFH, 1FFFH, 3FFFH or 7FFFH
// - stop or reset returns eprom range to largest: 32K or 16K
// - mask-rom variants ignore writes to the eprom range field
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH

// ==========================================
// register map (byte addresses)
`define ADDR_MEM_MAP 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_PORT_OUT 8'h08

// ==========================================
// memory map control fields
`define BUS_MODE_LSB 0
`define RAM_EN_BIT 3
`define EPROM_RANGE_LSB 5
`define EPROM_32K 3'h0
`define EPROM_16K 3'h1
`define EPROM_8K 3'h3
`define EPROM_4K 3'h7

// ==========================================
// address limits
`define LIM_4K 16'h0FFF
`define LIM_16K 16'h3FFF
`define LIM_FULL_BIG 16'hFBFF
`define LIM_FULL_SMALL 16'hFEFF
`define RAM_BASE_SMALL 16'hFF00
`define RAM_BASE_BIG 16'hFC00

// ==========================================
// timing
`define OSC_PER_STATE 2'd3
`define STATES_FETCH 3'd4
`define STATES_DATA 3'd3
`define CLK_PERIOD_NS 40

`endif

// ---- rtl/ext_bus_pkg.sv ----
/*
  types for the external bus block.
  assumes ext_bus_cfg.svh holds the numeric constants.
*/
package ext_bus_pkg;
  // ==========================================
  // window selected by the mode pins
  typedef enum logic [3:0] {
    WIN_4K = 4'b0001,
    WIN_16K = 4'b0010,
    WIN_BAD = 4'b0100,
    WIN_FULL = 4'b1000
  } window_type;

  // ==========================================
  // machine cycle kinds
  typedef enum logic [3:0] {
    CYC_IDLE = 4'b0001,
    CYC_FETCH = 4'b0010,
    CYC_READ = 4'b0100,
    CYC_WRITE = 4'b1000
  } cycle_type;
endpackage

// ---- rtl/ext_bus.sv ----
/*
  external bus controller: mode-pin windows, on-chip ram/eprom decode,
  multiplexed address/data bus with latch, read and write strobes,
  and a wishbone slave for the memory mapping register.
  assumes the core raises req_i for one clock while ready_o is high.
*/
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ext_bus_cfg.svh"

module ext_bus #(
  parameter bit BIG_RAM = 1'b1,
  parameter bit HAS_EPROM = 1'b1,
  parameter bit BIG_EPROM = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_i,
  // mode pins
  input wire logic window_select_pin_low_i,
  input wire logic window_select_pin_high_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // core request
  input wire logic req_i,
  input wire ext_bus_pkg::cycle_type kind_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ready_o,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic internal_o,
  // low bus port
  input wire logic [7:0] low_bus_port_i,
  output logic [7:0] low_bus_port_o,
  output logic [7:0] low_bus_port_oe_o,
  // high address port
  input wire logic [7:0] high_address_port_i,
  output logic [7:0] high_address_port_o,
  output logic [7:0] high_address_port_oe_o,
  // strobes
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o
);

  // ==========================================
  // window decode
  wire logic [1:0] pins = {window_select_pin_high_i, window_select_pin_low_i};
  ext_bus_pkg::window_type win;
  assign win = (pins == 2'b00) ? ext_bus_pkg::WIN_4K :
               (pins == 2'b01) ? ext_bus_pkg::WIN_16K :
               (pins == 2'b10) ? ext_bus_pkg::WIN_BAD : ext_bus_pkg::WIN_FULL;

  logic [2:0] bus_mode_r;
  logic ram_en_r;
  logic [2:0] eprom_range_r;
  logic [7:0] gpio_out_r;
  logic [7:0] gpio_oe_r;
  logic port_wr_r;

  wire logic [15:0] ram_base = (win == ext_bus_pkg::WIN_FULL && BIG_RAM) ?
                               `RAM_BASE_BIG : `RAM_BASE_SMALL;
  wire logic [15:0] ext_lim = (win == ext_bus_pkg::WIN_4K) ? `LIM_4K :
                              (win == ext_bus_pkg::WIN_16K) ? `LIM_16K :
                              BIG_RAM ? `LIM_FULL_BIG : `LIM_FULL_SMALL;

  function automatic logic [15:0] eprom_lim(input logic [2:0] code);
    case (code)
      `EPROM_32K: eprom_lim = `LIM_16K | 16'h4000;
      `EPROM_16K: eprom_lim = `LIM_16K;
      `EPROM_8K: eprom_lim = 16'h1FFF;
      default: eprom_lim = `LIM_4K;
    endcase
  endfunction

  // on-chip resources pre-empt the external cycle
  wire logic in_ram = ram_en_r && (addr_i >= ram_base);
  wire logic in_eprom = HAS_EPROM && (addr_i <= eprom_lim(eprom_range_r));
  // in full expansion the ram area falls through to the bus once the ram enable is cleared
  wire logic ram_to_ext = (win == ext_bus_pkg::WIN_FULL) && !ram_en_r &&
                          (addr_i >= ram_base);
  wire logic in_ext = !in_ram && !in_eprom && ((addr_i <= ext_lim) || ram_to_ext) &&
                      (win != ext_bus_pkg::WIN_BAD);
  // no port instruction check: the mode-bits zero assumption holds
  wire logic bus_mode_ok = (bus_mode_r == 3'h0);

  // ==========================================
  // state sequencer
  ext_bus_pkg::cycle_type cyc_r;
  logic ext_r;
  logic [1:0] osc_r;
  logic [2:0] st_r;
  logic [15:0] adr_r;
  logic [7:0] wd_r;
  logic busy_r;

  wire logic last_osc = (osc_r == `OSC_PER_STATE - 2'd1);
  wire logic [2:0] n_states = (cyc_r == ext_bus_pkg::CYC_FETCH) ?
                              `STATES_FETCH : `STATES_DATA;
  wire logic cyc_done = busy_r && last_osc && (st_r == n_states);
  wire logic mid_t1 = (st_r == 3'd1) && (osc_r != 2'd0);
  assign ready_o = !busy_r;
  assign internal_o = busy_r && !ext_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_r <= 1'b0;
      osc_r <= 2'd0;
      st_r <= 3'd1;
      cyc_r <= ext_bus_pkg::CYC_IDLE;
      ext_r <= 1'b0;
      adr_r <= 16'h0000;
      wd_r <= 8'h00;
    end
    else if (!busy_r)
    begin
      if (req_i)
      begin
        busy_r <= 1'b1;
        osc_r <= 2'd0;
        st_r <= 3'd1;
        cyc_r <= kind_i;
        ext_r <= (in_ext && kind_i != ext_bus_pkg::CYC_IDLE) ||
                 (port_wr_r && win == ext_bus_pkg::WIN_FULL);
        adr_r <= addr_i;
        wd_r <= wdata_i;
      end
    end
    else
    begin
      osc_r <= last_osc ? 2'd0 : osc_r + 2'd1;
      if (last_osc)
        st_r <= cyc_done ? 3'd1 : st_r + 3'd1;
      if (cyc_done)
        busy_r <= 1'b0;
    end
  end

  // ==========================================
  // pin timing
  wire logic is_rd = ext_r && (cyc_r == ext_bus_pkg::CYC_READ ||
                               cyc_r == ext_bus_pkg::CYC_FETCH);
  wire logic is_wr = ext_r && (cyc_r == ext_bus_pkg::CYC_WRITE ||
                               (port_wr_r && win == ext_bus_pkg::WIN_FULL));
  wire logic rd_end = (cyc_r == ext_bus_pkg::CYC_FETCH) ? (st_r == 3'd4) : (st_r == 3'd3);
  wire logic rd_low = busy_r && is_rd && (mid_t1 || (st_r > 3'd1 && !rd_end));
  wire logic wr_low = busy_r && is_wr && (mid_t1 || st_r == 3'd2);
  wire logic drive_low_adr = busy_r && (st_r == 3'd1);
  wire logic drive_wd = busy_r && is_wr && (st_r >= 3'd2);
  // sample read data at the last clock before the strobe rises
  wire logic sample = busy_r && is_rd && last_osc &&
                      (st_r == ((cyc_r == ext_bus_pkg::CYC_FETCH) ? 3'd3 : 3'd2));

  // high-port pins that carry address in each window
  wire logic [7:0] adr_mask = (win == ext_bus_pkg::WIN_4K) ? 8'h0F :
                              (win == ext_bus_pkg::WIN_16K) ? 8'h3F : 8'hFF;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      low_bus_port_o <= 8'h00;
      low_bus_port_oe_o <= 8'h00;
      high_address_port_o <= 8'h00;
      high_address_port_oe_o <= 8'h00;
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else
    begin
      ale_o <= busy_r && (st_r == 3'd1) && (osc_r != 2'd2);
      rd_n_o <= !rd_low;
      wr_n_o <= !wr_low;
      low_bus_port_o <= drive_low_adr ? adr_r[7:0] : wd_r;
      low_bus_port_oe_o <= (drive_low_adr || drive_wd) ? 8'hFF : 8'h00;
      high_address_port_o <= (busy_r ? adr_r[15:8] : 8'h00) & adr_mask |
                             gpio_out_r & ~adr_mask;
      high_address_port_oe_o <= (busy_r ? adr_mask : 8'h00) | (gpio_oe_r & ~adr_mask);
      rvalid_o <= sample;
      if (sample)
        rdata_o <= low_bus_port_i;
    end
  end

  // ==========================================
  // wishbone register slave, one wait cycle
  wire logic hit = cyc_i && stb_i && !ack_o;
  wire logic wr_mm = hit && we_i && sel_i[0] && adr_i == `ADDR_MEM_MAP;
  wire logic wr_port = hit && we_i && sel_i[0] && adr_i == `ADDR_PORT_OUT;
  wire logic [2:0] eprom_reset = BIG_EPROM ? `EPROM_32K : `EPROM_16K;
  wire logic [7:0] mm_view = {eprom_range_r, 1'b0, ram_en_r, bus_mode_r};
  wire logic [31:0] rd_mux = (adr_i == `ADDR_MEM_MAP) ? {24'h000000, mm_view} :
                             (adr_i == `ADDR_STATUS) ?
                             {16'h0000, high_address_port_i, 3'h0, bus_mode_ok,
                              win} :
                             (adr_i == `ADDR_PORT_OUT) ? {16'h0000, gpio_oe_r, gpio_out_r} :
                             32'h00000000;

  always_ff @(posedge clk_i)
  begin
    ack_o <= !rst_i && hit;
    dat_o <= rst_i ? 32'h00000000 : rd_mux;
    // held until the running or next core cycle ends at cyc_done, strobe or not; a new write wins
    port_wr_r <= !rst_i && ((wr_port && (win == ext_bus_pkg::WIN_FULL)) ||
                            (port_wr_r && !cyc_done));
    if (rst_i || stop_i)
      eprom_range_r <= eprom_reset;
    else if (wr_mm && HAS_EPROM)
    begin
      if (dat_i[7:5] == `EPROM_32K && !BIG_EPROM)
        eprom_range_r <= eprom_range_r;
      else if (dat_i[7:5] == `EPROM_32K || dat_i[7:5] == `EPROM_16K ||
               dat_i[7:5] == `EPROM_8K || dat_i[7:5] == `EPROM_4K)
        eprom_range_r <= dat_i[7:5];
    end
    if (rst_i)
    begin
      bus_mode_r <= 3'h0;
      gpio_out_r <= 8'h00;
      gpio_oe_r <= 8'h00;
    end
    else
    begin
      if (wr_mm)
        bus_mode_r <= dat_i[2:0];
      if (wr_port)
        gpio_out_r <= dat_i[7:0];
      if (wr_port && sel_i[1])
        gpio_oe_r <= dat_i[15:8];
    end
    // reset does not touch the ram enable
    if (wr_mm)
      ram_en_r <= dat_i[`RAM_EN_BIT];
  end

endmodule

// ---- testbench/ext_bus_props.sv ----
/* checker for the ext_bus strobes, cycle lengths and wishbone answer.
   assumes only the ports of ext_bus; bound to every instance. */
`timescale 1ns/100ps
module ext_bus_props (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic req_i,
  input wire ext_bus_pkg::cycle_type kind_i,
  input wire logic window_select_pin_high_i,
  input wire logic ready_o,
  input wire logic ale_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic [7:0] low_bus_port_oe_o
);
  // ==========================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take_w = req_i && ready_o;
  wb_ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  ack_one_cycle_a: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  fetch_length_a: assert property (take_w && kind_i == ext_bus_pkg::CYC_FETCH |=>
    !ready_o ##11 !ready_o ##1 ready_o) else $error("fetch length");
  data_length_a: assert property (take_w && kind_i != ext_bus_pkg::CYC_FETCH |=>
    !ready_o ##8 !ready_o ##1 ready_o) else $error("cycle length");
  strobe_excl_a: assert property (!(!rd_n_o && !wr_n_o))
    else $error("rd and wr both low");
  idle_quiet_a: assert property (take_w && kind_i == ext_bus_pkg::CYC_IDLE &&
    !window_select_pin_high_i |=> (rd_n_o && wr_n_o) [*8]) else $error("idle strobe");
  ale_each_a: assert property (take_w |-> ##[1:3] ale_o)
    else $error("no latch strobe");
  addr_drive_a: assert property (ale_o |-> low_bus_port_oe_o == 8'hFF)
    else $error("address not driven");
  read_release_a: assert property (!rd_n_o && !ale_o && !$past(ale_o) |->
    low_bus_port_oe_o == 8'h00)
    else $error("bus driven in read");
endmodule

bind ext_bus ext_bus_props props_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .req_i(req_i), .kind_i(kind_i), .ready_o(ready_o),
  .window_select_pin_high_i(window_select_pin_high_i), .ale_o(ale_o),
  .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .low_bus_port_oe_o(low_bus_port_oe_o));

// ---- testbench/ext_mem_model.sv ----
/* external 64K memory on the multiplexed bus.
   assumes resolved bus level on ad_i and the ext_bus strobes. */
`timescale 1ns/100ps
module ext_mem_model (
  // bus pins
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] ad_i,
  input wire logic [7:0] high_i,
  output logic [7:0] ad_o
);
  logic [7:0] mem_r [0:65535];
  logic [15:0] lat_r;
  // ==========================================
  // address only valid while latch strobe is up
  always @(posedge clk_i)
  begin
    if (ale_i)
      lat_r <= {high_i, ad_i};
    if (!wr_n_i)
      mem_r[lat_r] <= ad_i;
  end
  // undriven bus shows the inverse, so a stale byte cannot pass
  assign ad_o = rd_n_i ? ~mem_r[lat_r] : mem_r[lat_r];
endmodule

// ---- testbench/ext_bus_bench.sv ----
/* bench for ext_bus: wishbone register tasks, core cycles to ext_mem_model.
   assumes ext_bus_props is bound in. */
`timescale 1ns/100ps
module ext_bus_bench;
  logic clk, rst, lo, hi, cyc, stb, we, req, ack, ready, rvalid, ale, rd_n, wr_n;
  logic srd, swr, sale, hok;
  logic [7:0] adr, wdata, rdata, lbo, lboe, hbo, hboe, mdat, got;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, q;
  logic [15:0] addr;
  ext_bus_pkg::cycle_type kind;
  int miscompares, tests_run, cycles;
  wire [7:0] lbus = (lboe & lbo) | (~lboe & mdat);
  typedef struct packed {logic [1:0] m; logic [15:0] a; logic ext; logic [3:0] win;} row_type;
  row_type rows [6] = '{'{2'b00, 16'h0FFF, 1'b1, 4'h1}, '{2'b00, 16'h1000, 1'b0, 4'h1},
    '{2'b01, 16'h3FFF, 1'b1, 4'h2}, '{2'b01, 16'h4000, 1'b0, 4'h2},
    '{2'b11, 16'hFBFF, 1'b1, 4'h8}, '{2'b11, 16'hFC00, 1'b0, 4'h8}};
  ext_bus #(.BIG_RAM(1'b1), .HAS_EPROM(1'b0), .BIG_EPROM(1'b0)) dut_u (
    .clk_i(clk), .rst_i(rst), .stop_i(1'b0), .window_select_pin_low_i(lo),
    .window_select_pin_high_i(hi), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .req_i(req), .kind_i(kind),
    .addr_i(addr), .wdata_i(wdata), .ready_o(ready), .rdata_o(rdata), .rvalid_o(rvalid),
    .internal_o(), .low_bus_port_i(lbus), .low_bus_port_o(lbo), .low_bus_port_oe_o(lboe),
    .high_address_port_i(8'h5A), .high_address_port_o(hbo), .high_address_port_oe_o(hboe),
    .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n));
  ext_mem_model mem_u (.clk_i(clk), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .ad_i(lbus), .high_i(hbo), .ad_o(mdat));
  // ==========================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, w ? 4'h3 : 4'hF};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = dat_r;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic core(input ext_bus_pkg::cycle_type k, input logic [15:0] a);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    {req, kind, addr, wdata} <= {1'b1, k, a, 8'hA5};
    {srd, swr, sale, hok} = 4'b0001;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      srd |= (rd_n === 1'b0);
      swr |= (wr_n === 1'b0);
      sale |= (ale === 1'b1);
      if (n > 1)
        hok &= (hbo === a[15:8]);
      if (rvalid === 1'b1)
        got = rdata;
    end
    while (ready !== 1'b1 && n < 40);
  endtask
  // ==========================================
  // stimulus
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial
  begin
    {lo, hi, cyc, stb, we, req, adr, wdata, sel, dat_w, addr} = '0;
    rst = 1'b1;
    kind = ext_bus_pkg::CYC_IDLE;
    {miscompares, tests_run, cycles} = '0;
    repeat (4) @(posedge clk);
    check({ale, rd_n, wr_n, ack, lboe}, 12'h600);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b1, 8'h00, 32'h08);
    wb(1'b0, 8'h00, 32'h0);
    check(q[3:0], 4'h8);
    wb(1'b0, 8'h0C, 32'h0);
    check(q, 32'h0);
    wb(1'b1, 8'h08, 32'hF0A0);
    @(posedge clk);
    check({hboe[7:4], hbo[7:4]}, 8'hFA);
    core(ext_bus_pkg::CYC_IDLE, 16'h0123);
    check({srd, swr, sale}, 3'b001);
    foreach (rows[i])
    begin
      {hi, lo} <= rows[i].m;
      @(posedge clk);
      wb(1'b0, 8'h04, 32'h0);
      check(q[3:0], rows[i].win);
      core(ext_bus_pkg::CYC_READ, rows[i].a);
      check({srd, sale}, {rows[i].ext, 1'b1});
    end
    core(ext_bus_pkg::CYC_WRITE, 16'h1234);
    check({swr, srd, hok}, 3'b101);
    core(ext_bus_pkg::CYC_READ, 16'h1234);
    check({got, hok}, 9'h14B);
    got = 8'h00;
    core(ext_bus_pkg::CYC_FETCH, 16'h1234);
    check({got, hok}, 9'h14B);
    wb(1'b1, 8'h08, 32'h0);
    core(ext_bus_pkg::CYC_IDLE, 16'h0000);
    check(swr, 1'b1);
    {hi, lo} <= 2'b10;
    @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    check(q[3:0], 4'h4);
    {hi, lo} <= 2'b11;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 8'h00, 32'h0);
    check(q[3], 1'b1);
    wb(1'b1, 8'h00, 32'h0);
    core(ext_bus_pkg::CYC_READ, 16'hFC00);
    check(srd, 1'b1);
    tally_and_finish;
  end
endmodule
